//--- hw/hyp_trap_syndrome_encoder.sv
// Hypervisor trap syndrome encoder with its syndrome register
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "hyp_syndrome_cfg.svh"

// How it works
// [RULE1] Length flag: 0 for 16-bit, 1 for 32-bit
// [RULE2] Length flag forced 1 for listed classes
// [RULE3] Alignment fault length flag left as given
// [RULE4] Low 25 bits chosen by class layout
// [RULE5] Unknown class: syndrome zero, fallback class
// [RULE6] Unallocated, unimplemented, vector, absent FP: unknown
// [RULE7] Disabled hyp call, halt, banked move: unknown
// [RULE8] Disallowed debug switches report unknown class
// [RULE9] Failed-condition wait never traps
// [RULE10] Wait syndrome: bit0 kind, 19..1 zero
// [RULE11] Condition-valid set for fixed-width instructions
// [RULE12] Condition copied, or 0xE if unconditional
// [RULE13] Passed conditional may report either value
// [RULE14] Mixed-width: flag clear, or valid condition
// [RULE15] Coprocessor layout for 1111, 1110, FP reads
// [RULE16] Second opcode at 19..17, FP gives 000
// [RULE17] First opcode at 16..14, FP gives 111
// [RULE18] Primary register at 13..10, FP register-select
// [RULE19] Class codes written to bits 31..26
// [RULE20] Transfer register at 8..5, bit 9 zero
// [RULE21] Secondary register at 4..1, FP zero
// [RULE22] Bit0 direction: write 0, read 1
// [RULE23] Whole record written in one cycle
module hyp_trap_syndrome_encoder (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Trap from the pipeline
    input  wire hyp_syndrome_pkg::trap_info_t   trap_in,
    input  wire hyp_syndrome_pkg::undef_cause_t undef_in,
    // Trap taken to hypervisor mode
    output logic                           trap_taken,
    // Register port
    input  wire logic [`HSE_ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [31:0]                    reg_rdata
);

    // Condition field for fixed-width or mixed-width instructions
    function automatic logic [4:0] code_field_a_bits(input hyp_syndrome_pkg::trap_info_t t, input logic mixed_valid,
                                             input logic passed_as_always);
        logic [3:0] c;
        c = t.code_field_a;
        if (!t.is_conditional || (passed_as_always && t.code_field_a_passed)) begin
            c = `HSE_CODE_FIELD_A_ALWAYS;                                     // [RULE12] [RULE13]
        end
        if (t.is_mixed_width && !mixed_valid) begin
            code_field_a_bits = {1'b0, 4'h0};                                 // [RULE14]
        end else begin
            code_field_a_bits = {1'b1, c};                                    // [RULE11] [RULE14]
        end
    endfunction

    logic                                  undef_hit;
    logic                                  wait_fail;
    logic                                  take;
    hyp_syndrome_pkg::syndrome_t           rec;
    logic [4:0]                            cv_code_field_a;
    hyp_syndrome_pkg::syndrome_t           syn_d;
    hyp_syndrome_pkg::syndrome_t           syn_q;
    logic [31:0]                           count_d;
    logic [31:0]                           count_q;
    logic [1:0]                            cfg_d;
    logic [1:0]                            cfg_q;
    logic                                  taken_d;
    logic                                  taken_q;
    logic [31:0]                           rdata_d;
    logic [31:0]                           rdata_q;

    // Unknown-reason causes take priority over the decoded class
    always_comb begin
        undef_hit = undef_in.unallocated | undef_in.unimplemented
                  | undef_in.short_vector_fp | undef_in.fp_absent_access;                 // [RULE6]
        undef_hit = undef_hit
                  | (undef_in.hyp_call & undef_in.hyp_call_disable)
                  | (undef_in.halt_instr & ~undef_in.halt_debug_enable)
                  | undef_in.banked_inaccessible;                                         // [RULE7]
        undef_hit = undef_hit
                  | (undef_in.debug_state & undef_in.dsw1 & undef_in.at_level0
                     & undef_in.trap_general_exceptions)
                  | (undef_in.debug_state & undef_in.dsw2
                     & (undef_in.at_level0 | undef_in.at_level1)
                     & (undef_in.hyp_debug_disable | undef_in.hyp_level_absent));        // [RULE8]
    end

    always_comb begin
        wait_fail = (trap_in.kind == hyp_syndrome_pkg::TRAP_WAIT)
                  & trap_in.is_conditional & ~trap_in.code_field_a_passed;                      // [RULE9]
        take      = trap_in.valid & (undef_hit | (trap_in.kind != hyp_syndrome_pkg::TRAP_NONE)) & ~wait_fail;
        cv_code_field_a   = code_field_a_bits(trap_in, cfg_q[0], cfg_q[1]);
    end

    // Record builder
    always_comb begin
        rec.exception_class   = `HSE_EC_UNKNOWN;
        rec.instr_length_flag = trap_in.is_32bit;                                        // [RULE1]
        rec.class_syndrome    = 25'h0000000;
        if (undef_hit) begin
            rec.exception_class   = `HSE_EC_UNKNOWN;                                     // [RULE5]
            rec.instr_length_flag = 1'b1;                                                // [RULE2]
            rec.class_syndrome    = 25'h0000000;                                         // [RULE5]
        end else begin
            case (trap_in.kind)
                hyp_syndrome_pkg::TRAP_WAIT: begin
                    rec.exception_class = `HSE_EC_WAIT;                                  // [RULE19]
                    rec.class_syndrome  = {cv_code_field_a, 19'h00000, trap_in.wait_is_event};  // [RULE10] [RULE4]
                end
                hyp_syndrome_pkg::TRAP_COPROC: begin
                    if (trap_in.coproc == `HSE_COPROC_CP15) begin
                        rec.exception_class = `HSE_EC_CP15_XFER;                         // [RULE15] [RULE19]
                        rec.class_syndrome  = {cv_code_field_a, trap_in.second_opcode_field, trap_in.first_opcode_field, trap_in.primary_coproc_reg_field, 1'b0,
                                               trap_in.rt, trap_in.secondary_coproc_reg_field, trap_in.is_read}; // [RULE16] [RULE17] [RULE18] [RULE20] [RULE21] [RULE22]
                    end else if (trap_in.coproc == `HSE_COPROC_CP14) begin
                        rec.exception_class = `HSE_EC_CP14_XFER;                         // [RULE15] [RULE19]
                        rec.class_syndrome  = {cv_code_field_a, trap_in.second_opcode_field, trap_in.first_opcode_field, trap_in.primary_coproc_reg_field, 1'b0,
                                               trap_in.rt, trap_in.secondary_coproc_reg_field, trap_in.is_read}; // [RULE16] [RULE20] [RULE22]
                    end else begin
                        rec.exception_class   = `HSE_EC_UNKNOWN;                         // [RULE5]
                        rec.instr_length_flag = 1'b1;                                    // [RULE2]
                    end
                end
                hyp_syndrome_pkg::TRAP_FP_READ: begin
                    rec.exception_class = `HSE_EC_FP_ID_READ;                            // [RULE15] [RULE19]
                    rec.class_syndrome  = {cv_code_field_a, `HSE_FP_SECOND_OPCODE_FIELD, `HSE_FP_FIRST_OPCODE_FIELD, trap_in.fp_reg, 1'b0,
                                           trap_in.rt, `HSE_FP_CRM, 1'b1};               // [RULE16] [RULE17] [RULE18] [RULE21] [RULE22]
                end
                hyp_syndrome_pkg::TRAP_PASS: begin
                    rec.exception_class = trap_in.pass_class;
                    rec.class_syndrome  = trap_in.pass_iss;                              // [RULE4]
                    case (trap_in.pass_class)
                        `HSE_EC_ILLEGAL_STATE,
                        `HSE_EC_PABT_LOWER,
                        `HSE_EC_PABT_SAME: begin
                            rec.instr_length_flag = 1'b1;                                // [RULE2]
                        end
                        `HSE_EC_DABT_LOWER,
                        `HSE_EC_DABT_SAME: begin
                            if (!trap_in.pass_iss_valid) begin
                                rec.instr_length_flag = 1'b1;                            // [RULE2]
                            end
                        end
                        `HSE_EC_PC_ALIGN: begin
                            rec.instr_length_flag = trap_in.is_32bit;                    // [RULE3]
                        end
                        default: begin
                            rec.instr_length_flag = trap_in.is_32bit;
                        end
                    endcase
                end
                default: begin
                    rec.exception_class   = `HSE_EC_UNKNOWN;                             // [RULE5]
                    rec.instr_length_flag = 1'b1;                                        // [RULE2]
                    rec.class_syndrome    = 25'h0000000;
                end
            endcase
        end
    end

    // Register next values: a trap wins over a software write in the same cycle
    always_comb begin
        syn_d   = syn_q;
        count_d = count_q;
        cfg_d   = cfg_q;
        taken_d = take;
        if (reg_write && reg_addr == `HSE_OFF_SYNDROME) begin
            syn_d = hyp_syndrome_pkg::syndrome_t'(reg_wdata);
        end
        if (reg_write && reg_addr == `HSE_OFF_STATUS) begin
            count_d = 32'h00000000;
        end
        if (reg_write && reg_addr == `HSE_OFF_CONFIG) begin
            cfg_d = reg_wdata[1:0];
        end
        if (take) begin
            syn_d   = rec;                                                               // [RULE23]
            count_d = count_q + 32'h00000001;
        end
        rdata_d = 32'h00000000;
        if (reg_read) begin
            case (reg_addr)
                `HSE_OFF_SYNDROME: rdata_d = syn_q;
                `HSE_OFF_STATUS:   rdata_d = count_q;
                `HSE_OFF_CONFIG:   rdata_d = {30'h00000000, cfg_q};
                default:           rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            syn_q   <= '0;
            count_q <= 32'h00000000;
            cfg_q   <= 2'h1;
            taken_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            syn_q   <= syn_d;
            count_q <= count_d;
            cfg_q   <= cfg_d;
            taken_q <= taken_d;
            rdata_q <= rdata_d;
        end
    end

    assign trap_taken = taken_q;
    assign reg_rdata  = rdata_q;

endmodule // hyp_trap_syndrome_encoder
`default_nettype wire

//--- hw/hyp_syndrome_cfg.svh
// Fixed field values, class codes and register offsets of the trap syndrome encoder
`ifndef HYP_SYNDROME_CFG_SVH
`define HYP_SYNDROME_CFG_SVH

`define HSE_ADDR_W              4
`define HSE_OFF_SYNDROME        4'h0
`define HSE_OFF_STATUS          4'h4
`define HSE_OFF_CONFIG          4'h8
`define HSE_EC_UNKNOWN          6'h00
`define HSE_EC_WAIT             6'h01
`define HSE_EC_CP15_XFER        6'h03
`define HSE_EC_CP14_XFER        6'h05
`define HSE_EC_FP_ID_READ       6'h08
`define HSE_EC_ILLEGAL_STATE    6'h0E
`define HSE_EC_PC_ALIGN         6'h22
`define HSE_EC_PABT_LOWER       6'h20
`define HSE_EC_PABT_SAME        6'h21
`define HSE_EC_DABT_LOWER       6'h24
`define HSE_EC_DABT_SAME        6'h25
`define HSE_CODE_FIELD_A_ALWAYS         4'hE
`define HSE_FP_SECOND_OPCODE_FIELD             3'h0
`define HSE_FP_FIRST_OPCODE_FIELD             3'h7
`define HSE_FP_CRM              4'h0
`define HSE_COPROC_CP15         4'hF
`define HSE_COPROC_CP14         4'hE

`endif

//--- hw/hyp_syndrome_pkg.sv
// Types shared by the trap syndrome encoder
package hyp_syndrome_pkg;

    typedef enum logic [2:0] {
        TRAP_NONE     = 3'b000,
        TRAP_UNDEF    = 3'b001,
        TRAP_WAIT     = 3'b010,
        TRAP_COPROC   = 3'b011,
        TRAP_FP_READ  = 3'b100,
        TRAP_PASS     = 3'b101
    } trap_kind_t;

    // Decoded trap from the pipeline
    typedef struct packed {
        logic       valid;
        trap_kind_t kind;
        logic [5:0] pass_class;
        logic       pass_iss_valid;
        logic [24:0] pass_iss;
        logic       is_32bit;
        logic       is_mixed_width;
        logic       is_conditional;
        logic [3:0] code_field_a;
        logic       code_field_a_passed;
        logic       wait_is_event;
        logic [3:0] coproc;
        logic [2:0] first_opcode_field;
        logic [2:0] second_opcode_field;
        logic [3:0] primary_coproc_reg_field;
        logic [3:0] secondary_coproc_reg_field;
        logic [3:0] rt;
        logic       is_read;
        logic [3:0] fp_reg;
    } trap_info_t;

    // Undefined-cause conditions
    typedef struct packed {
        logic unallocated;
        logic unimplemented;
        logic short_vector_fp;
        logic fp_absent_access;
        logic hyp_call;
        logic hyp_call_disable;
        logic halt_instr;
        logic halt_debug_enable;
        logic banked_inaccessible;
        logic debug_state;
        logic dsw1;
        logic dsw2;
        logic at_level0;
        logic at_level1;
        logic trap_general_exceptions;
        logic hyp_debug_disable;
        logic hyp_level_absent;
    } undef_cause_t;

    typedef struct packed {
        logic [5:0]  exception_class;
        logic        instr_length_flag;
        logic [24:0] class_syndrome;
    } syndrome_t;

endpackage

//--- test/hyp_syndrome_checker_asserts.sv
// Property checker for the trap syndrome encoder ports
`timescale 1ns/100ps
`default_nettype none
module hyp_syndrome_checker (
    // Clock and reset
    input wire logic                           clk,
    input wire logic                           reset,
    // Pipeline side
    input wire hyp_syndrome_pkg::trap_info_t   trap_in,
    input wire hyp_syndrome_pkg::undef_cause_t undef_in,
    input wire logic                           trap_taken,
    // Register port
    input wire logic [3:0]                     reg_addr,
    input wire logic [31:0]                    reg_wdata,
    input wire logic                           reg_write,
    input wire logic                           reg_read,
    input wire logic [31:0]                    reg_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    hyp_syndrome_pkg::trap_info_t t_q;
    logic                         u_q, z_q, ok_q, drop, sy, w, x, f;
    assign drop = trap_in.kind == hyp_syndrome_pkg::TRAP_WAIT && trap_in.is_conditional && !trap_in.code_field_a_passed
                  && undef_in == '0;
    // Syndrome read with the last accepted trap still in the register
    assign sy = ok_q && reg_read && reg_addr == 4'h0 && !trap_in.valid;
    assign w = sy && z_q && t_q.kind == hyp_syndrome_pkg::TRAP_WAIT;
    assign x = sy && z_q && t_q.kind == hyp_syndrome_pkg::TRAP_COPROC && t_q.coproc inside {4'hE, 4'hF};
    assign f = sy && z_q && t_q.kind == hyp_syndrome_pkg::TRAP_FP_READ;
    always_ff @(posedge clk) begin
        if (trap_in.valid && !drop) begin
            t_q <= trap_in;
            u_q <= |undef_in[16:13];
            z_q <= undef_in == '0;
        end
        ok_q <= !reset && ((trap_in.valid && !drop) || (ok_q && !reg_write));
    end
    a_drop_not_taken: assert property (trap_in.valid && drop |=> !trap_taken)
        else $error("failed wait was taken");
    a_trap_taken_next: assert property (trap_in.valid && !drop && trap_in.kind != hyp_syndrome_pkg::TRAP_NONE
        |=> trap_taken)
        else $error("trap not taken");
    a_wait_layout: assert property (w |=> reg_rdata[31:26] == 6'h01 && reg_rdata[19:0] == {19'h0, t_q.wait_is_event})
        else $error("wait syndrome layout wrong");
    a_wait_length: assert property (w |=> reg_rdata[25] == t_q.is_32bit)
        else $error("length flag wrong");
    a_wait_code_field_a: assert property (w && !t_q.is_mixed_width |=> reg_rdata[24] && (reg_rdata[23:20] == (t_q.is_conditional ? t_q.code_field_a : 4'hE)
        || (t_q.is_conditional && t_q.code_field_a_passed && reg_rdata[23:20] == 4'hE)))
        else $error("condition field wrong");
    a_unknown_zero: assert property (sy && u_q |=> reg_rdata == 32'h0200_0000)
        else $error("unknown syndrome wrong");
    a_xfer_fields: assert property (x |=> reg_rdata[31:26] == (t_q.coproc == 4'hF ? 6'h03 : 6'h05)
        && reg_rdata[19:0] == {t_q.second_opcode_field, t_q.first_opcode_field, t_q.primary_coproc_reg_field, 1'b0, t_q.rt, t_q.secondary_coproc_reg_field, t_q.is_read})
        else $error("transfer syndrome wrong");
    a_fp_fields: assert property (f |=> reg_rdata[31:26] == 6'h08
        && reg_rdata[19:0] == {3'h0, 3'h7, t_q.fp_reg, 1'b0, t_q.rt, 4'h0, 1'b1})
        else $error("fp read syndrome wrong");
    c_drop: cover property (trap_in.valid && drop);
    c_unknown: cover property (sy && u_q);
    c_xfer: cover property (x);
    c_wait: cover property (w);
endmodule // hyp_syndrome_checker
bind hyp_trap_syndrome_encoder hyp_syndrome_checker chk (.clk(clk), .reset(reset), .trap_in(trap_in),
    .undef_in(undef_in), .trap_taken(trap_taken), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
`default_nettype wire

//--- test/trap_source.sv
// Pipeline model that hands decoded traps to the encoder
`timescale 1ns/100ps
`default_nettype none
module trap_source (
    // Clock
    input  wire logic                      clk,
    // Decoded trap toward the encoder
    output hyp_syndrome_pkg::trap_info_t   trap_out,
    output hyp_syndrome_pkg::undef_cause_t undef_out
);
    initial begin
        trap_out = '0;
        undef_out = '0;
    end
    // One-cycle pulse; idle fields turn to garbage so stale values are never trusted
    task automatic send(input hyp_syndrome_pkg::trap_info_t t, input hyp_syndrome_pkg::undef_cause_t u);
        hyp_syndrome_pkg::trap_info_t idle;
        idle = ~t;
        idle.valid = 1'b0;
        @(posedge clk);
        trap_out <= t;
        undef_out <= u;
        @(posedge clk);
        trap_out <= idle;
        undef_out <= ~u;
    endtask
endmodule // trap_source
`default_nettype wire

//--- test/hyp_trap_syndrome_encoder_bench.sv
// Self-checking bench for the trap syndrome encoder
`timescale 1ns/100ps
`default_nettype none
module hyp_trap_syndrome_encoder_bench;
    logic                           clk = 1'b0;
    logic                           reset = 1'b1;
    logic                           trap_taken;
    logic                           reg_write = 1'b0;
    logic                           reg_read = 1'b0;
    logic [3:0]                     reg_addr = 4'h0;
    logic [31:0]                    reg_wdata = 32'h0;
    logic [31:0]                    reg_rdata;
    int                             num_errors = 0;
    int                             compares = 0;
    hyp_syndrome_pkg::trap_info_t   tr;
    hyp_syndrome_pkg::undef_cause_t ui;
    always #2.5 clk = ~clk;
    trap_source pipe (.clk(clk), .trap_out(tr), .undef_out(ui));
    hyp_trap_syndrome_encoder dut (.clk(clk), .reset(reset), .trap_in(tr), .undef_in(ui), .trap_taken(trap_taken),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // Sends one trap, checks the taken pulse, then reads the syndrome back
    task automatic run(input hyp_syndrome_pkg::trap_info_t t, input logic [16:0] u, input logic tk,
                       input logic [31:0] exp);
        logic [31:0] d;
        pipe.send(t, u);
        #1 check("taken", {31'h0, tk}, {31'h0, trap_taken});
        rd(4'h0, d);
        check("syndrome", exp, d);
    endtask
    task automatic test_regs;
        logic [31:0] d;
        rd(4'h0, d);
        check("reset syndrome", 32'h0, d);
        rd(4'h4, d);
        check("reset count", 32'h0, d);
        rd(4'h8, d);
        check("reset config", 32'h1, d);
        rd(4'hC, d);
        check("unmapped read", 32'h0, d);
        wr(4'h0, 32'hA5A5_5A5A);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'h0, d);
        check("syndrome rw", 32'hA5A5_5A5A, d);
        $display("test_regs done");
    endtask
    task automatic test_wait;
        hyp_syndrome_pkg::trap_info_t t;
        logic [31:0]                  e;
        for (int i = 0; i < 4; i++) begin
            t = '0;
            t.valid = 1'b1;
            t.kind = hyp_syndrome_pkg::TRAP_WAIT;
            t.is_32bit = 1'b1;
            t.wait_is_event = i[0];
            t.is_conditional = i[1];
            t.code_field_a = 4'h3;
            t.code_field_a_passed = 1'b1;
            e = {6'h01, 2'b11, i[1] ? 4'h3 : 4'hE, 19'h0, i[0]};
            run(t, '0, 1'b1, e);
        end
        t.code_field_a_passed = 1'b0;
        run(t, '0, 1'b0, e);
        t.is_conditional = 1'b0;
        t.is_32bit = 1'b0;
        t.is_mixed_width = 1'b1;
        run(t, '0, 1'b1, {6'h01, 2'b01, 4'hE, 20'h1});
        run(t, 17'h00600, 1'b1, {6'h01, 2'b01, 4'hE, 20'h1});
        $display("test_wait done");
    endtask
    task automatic test_xfer;
        hyp_syndrome_pkg::trap_info_t t;
        t = '0;
        t.valid = 1'b1;
        t.kind = hyp_syndrome_pkg::TRAP_COPROC;
        t.is_32bit = 1'b1;
        t.second_opcode_field = 3'h5;
        t.first_opcode_field = 3'h2;
        t.primary_coproc_reg_field = 4'h9;
        t.secondary_coproc_reg_field = 4'h6;
        t.rt = 4'hC;
        for (int i = 0; i < 4; i++) begin
            t.coproc = i[1] ? 4'hE : 4'hF;
            t.is_read = i[0];
            run(t, '0, 1'b1, {i[1] ? 6'h05 : 6'h03, 6'h3E, 3'h5, 3'h2, 4'h9, 1'b0, 4'hC, 4'h6, i[0]});
        end
        t.kind = hyp_syndrome_pkg::TRAP_FP_READ;
        t.fp_reg = 4'h7;
        t.rt = 4'h3;
        t.is_read = 1'b0;
        run(t, '0, 1'b1, {6'h08, 6'h3E, 3'h0, 3'h7, 4'h7, 1'b0, 4'h3, 4'h0, 1'b1});
        t.kind = hyp_syndrome_pkg::TRAP_COPROC;
        t.coproc = 4'hA;
        run(t, '0, 1'b1, 32'h0200_0000);
        $display("test_xfer done");
    endtask
    task automatic test_undef;
        hyp_syndrome_pkg::trap_info_t t;
        logic [16:0]                  c [10] = '{17'h10000, 17'h08000, 17'h04000, 17'h02000, 17'h01800,
                                                 17'h00400, 17'h00100, 17'h000D4, 17'h000AA, 17'h000B1};
        logic [5:0]                   k [3] = '{6'h20, 6'h21, 6'h0E};
        t = '0;
        t.valid = 1'b1;
        t.kind = hyp_syndrome_pkg::TRAP_WAIT;
        for (int i = 0; i < 10; i++) run(t, c[i], 1'b1, 32'h0200_0000);
        t.kind = hyp_syndrome_pkg::TRAP_PASS;
        t.pass_iss_valid = 1'b1;
        t.pass_iss = 25'h0ABCDE;
        for (int i = 0; i < 3; i++) begin
            t.pass_class = k[i];
            run(t, '0, 1'b1, {k[i], 1'b1, 25'h0ABCDE});
        end
        $display("test_undef done");
    endtask
    // Trap count register and the condition-field options of the config register
    task automatic test_cfg;
        hyp_syndrome_pkg::trap_info_t t;
        logic [31:0]                  d;
        rd(4'h4, d);
        check("trap count", 32'h19, d);
        wr(4'h4, 32'h0);
        rd(4'h4, d);
        check("count cleared", 32'h0, d);
        wr(4'h8, 32'h0);
        rd(4'h8, d);
        check("config rw", 32'h0, d);
        t = '0;
        t.valid = 1'b1;
        t.kind = hyp_syndrome_pkg::TRAP_WAIT;
        t.is_mixed_width = 1'b1;
        t.wait_is_event = 1'b1;
        t.is_conditional = 1'b1;
        t.code_field_a = 4'h5;
        t.code_field_a_passed = 1'b1;
        run(t, '0, 1'b1, {6'h01, 2'b00, 4'h0, 20'h1});
        wr(4'h8, 32'h2);
        t.is_mixed_width = 1'b0;
        t.is_32bit = 1'b1;
        run(t, '0, 1'b1, {6'h01, 2'b11, 4'hE, 20'h1});
        rd(4'h4, d);
        check("count after two", 32'h2, d);
        $display("test_cfg done");
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        test_regs;
        test_wait;
        test_xfer;
        test_undef;
        test_cfg;
        print_verdict;
    end
endmodule // hyp_trap_syndrome_encoder_bench
`default_nettype wire
